// file: verilog/laor_cfg.svh
// Offsets, field positions, reset values and timing counts of the lane alarm / offset trim slice
`ifndef LAOR_CFG_SVH
`define LAOR_CFG_SVH

// Printed register indices; byte address is four times the index
`define LAOR_IDX_ALARM_STATUS 10'h2c1
`define LAOR_IDX_LANE_FLAGS 10'h2c4
`define LAOR_IDX_TRIM0 10'h330
`define LAOR_IDX_TRIM1 10'h332
`define LAOR_IDX_CAL_CTRL 10'h340
`define LAOR_IDX_CAL_STAT 10'h341
`define LAOR_IDX_INT_STAT 10'h342
`define LAOR_IDX_INT_MASK 10'h343

// Fields
`define LAOR_SUMMARY_BIT 5
`define LAOR_TRIM_W 12
`define LAOR_CTRL_OFS_EN 0
`define LAOR_CTRL_BG_EN 1
`define LAOR_CTRL_BGOS 2
`define LAOR_CTRL_START 3
`define LAOR_INT_LANE 0
`define LAOR_INT_CAL 1

// Reset values
`define LAOR_LANE_FLAGS_RST 8'hff
`define LAOR_TRIM_RST 16'h0000
`define LAOR_SUMMARY_RST 1'b1

// Bus answers
`define LAOR_RESP_OKAY 2'h0
`define LAOR_RESP_SLVERR 2'h2

// Timing: foreground offset calibration length
`define LAOR_CLK_PERIOD_NS 25
`define LAOR_FG_CAL_TIME_NS 10000
`define LAOR_FG_CAL_CYCLES ((`LAOR_FG_CAL_TIME_NS + `LAOR_CLK_PERIOD_NS - 1) / `LAOR_CLK_PERIOD_NS)

`endif

// file: verilog/laor_pkg.sv
// Types shared by the lane alarm / offset trim slice
`default_nettype none
package laor_pkg;
    typedef enum logic [1:0] {
        LAOR_CAL_IDLE,
        LAOR_CAL_FG,
        LAOR_BACKGROUND_CAL_ENABLE
    } laor_cal_state_t;
endpackage
`default_nettype wire

// file: verilog/laor_cal_engine.sv
// Offset calibration sequencer: foreground step, then optional continuous background
`include "laor_cfg.svh"
`default_nettype none
module laor_cal_engine
    import laor_pkg::*;
#(
    parameter int FG_CYCLES = `LAOR_FG_CAL_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic ofs_en,
    input wire logic bg_en,
    input wire logic bgos_en,
    // Status
    output logic busy,
    output logic foreground_cal_complete,
    output logic done_pulse,
    output logic spare_cal
);
    laor_cal_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic foreground_cal_complete_r, foreground_cal_complete_nxt;
    logic pulse_r, pulse_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        foreground_cal_complete_nxt = foreground_cal_complete_r;
        pulse_nxt = 1'b0;
        unique case (state_r)
            LAOR_CAL_IDLE: begin
                if (start && ofs_en) begin
                    state_nxt = LAOR_CAL_FG;
                    cnt_nxt = 16'(FG_CYCLES - 1);
                    foreground_cal_complete_nxt = 1'b0;
                end
            end
            LAOR_CAL_FG: begin
                if (cnt_r == 16'h0000) begin
                    foreground_cal_complete_nxt = 1'b1;
                    pulse_nxt = 1'b1;
                    // Continuous mode keeps the trims until ofs_en, bg_en or bgos_en is cleared
                    state_nxt = (bg_en && bgos_en) ? LAOR_BACKGROUND_CAL_ENABLE : LAOR_CAL_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            LAOR_BACKGROUND_CAL_ENABLE: begin
                if (!(ofs_en && bg_en && bgos_en)) begin
                    state_nxt = LAOR_CAL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LAOR_CAL_IDLE;
            cnt_r <= 16'h0000;
            foreground_cal_complete_r <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            foreground_cal_complete_r <= foreground_cal_complete_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign busy = (state_r != LAOR_CAL_IDLE);
    assign foreground_cal_complete = foreground_cal_complete_r;
    assign done_pulse = pulse_r;
    // Spare cores get their offsets in the foreground step when bg_en is set and bgos_en is clear
    assign spare_cal = (state_r == LAOR_CAL_FG) && bg_en && !bgos_en;

    property p_spare_cal;
        @(posedge clk) disable iff (!rst_n)
        (busy && !foreground_cal_complete && bg_en && !bgos_en) |-> spare_cal;
    endproperty
    a_spare_cal: assert property (p_spare_cal) else $error("spare cores not calibrated");

    property p_fg_len;
        @(posedge clk) disable iff (!rst_n)
        ($rose(busy) && state_r == LAOR_CAL_FG) |-> !foreground_cal_complete ##1 (!foreground_cal_complete)[*7];
    endproperty
    a_fg_len: assert property (p_fg_len) else $error("foreground done too early");
endmodule // laor_cal_engine
`default_nettype wire

// file: verilog/laor_regs.sv
// Lane FIFO fault flags, alarm summary and core offset trims behind an AXI4-Lite slave
`include "laor_cfg.svh"
`default_nettype none

module laor_regs
    import laor_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int LANES = 8,
    parameter int FG_CYCLES = `LAOR_FG_CAL_CYCLES
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Lane FIFO faults and fuse defaults, asynchronous
    input wire logic [LANES-1:0] LANE_FIFO_FAULT,
    input wire logic FUSE_VALID,
    input wire logic [11:0] FUSE_TRIM0,
    input wire logic [11:0] FUSE_TRIM1,
    // Core offset corrections and status
    output logic [11:0] CORE0_OFFSET,
    output logic [11:0] CORE1_OFFSET,
    output logic SPARE_OFS_CAL,
    output logic CAL_BUSY,
    output logic IRQ
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = 10'(a >> 2);
    endfunction

    function automatic logic is_trim(input logic [9:0] i);
        is_trim = (i == `LAOR_IDX_TRIM0) || (i == `LAOR_IDX_TRIM1);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [LANES-1:0] fault_s1_r, fault_s2_r;
    logic fuse_s1_r, fuse_s2_r;
    logic [11:0] fz0_s1_r, fz0_s2_r, fz1_s1_r, fz1_s2_r;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fault_s1_r <= '0;
            fault_s2_r <= '0;
            fuse_s1_r <= 1'b0;
            fuse_s2_r <= 1'b0;
            fz0_s1_r <= 12'h000;
            fz0_s2_r <= 12'h000;
            fz1_s1_r <= 12'h000;
            fz1_s2_r <= 12'h000;
        end else begin
            fault_s1_r <= LANE_FIFO_FAULT;
            fault_s2_r <= fault_s1_r;
            fuse_s1_r <= FUSE_VALID;
            fuse_s2_r <= fuse_s1_r;
            fz0_s1_r <= FUSE_TRIM0;
            fz0_s2_r <= fz0_s1_r;
            fz1_s1_r <= FUSE_TRIM1;
            fz1_s2_r <= fz1_s1_r;
        end
    end

    // ****************************************
    // Calibration engine
    // ****************************************
    logic [2:0] cal_ctrl_r, cal_ctrl_nxt;
    logic cal_start_r, cal_start_nxt;
    logic cal_busy, cal_foreground_cal_complete, cal_done_pulse, spare_cal;

    laor_cal_engine #(.FG_CYCLES(FG_CYCLES)) u_cal (
        .clk(REF_CLK),
        .rst_n(ARST_N),
        .start(cal_start_r),
        .ofs_en(cal_ctrl_r[`LAOR_CTRL_OFS_EN]),
        .bg_en(cal_ctrl_r[`LAOR_CTRL_BG_EN]),
        .bgos_en(cal_ctrl_r[`LAOR_CTRL_BGOS]),
        .busy(cal_busy),
        .foreground_cal_complete(cal_foreground_cal_complete),
        .done_pulse(cal_done_pulse),
        .spare_cal(spare_cal)
    );

    // ****************************************
    // Bus channels
    // ****************************************
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic do_write;
    logic [9:0] widx, ridx;

    // ****************************************
    // Register state
    // ****************************************
    logic [LANES-1:0] lane_flags_r, lane_flags_nxt;
    logic summary_r, summary_nxt;
    logic [15:0] trim0_r, trim0_nxt, trim1_r, trim1_nxt;
    logic fuse_done_r, fuse_done_nxt;
    logic [1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
    logic irq_r, irq_nxt;
    logic [LANES-1:0] lane_clr;
    logic wr_ok;

    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign widx = reg_index(awaddr_r);
    assign ridx = reg_index(ARADDR);
    // Trim accesses are refused while the calibration engine owns them
    assign wr_ok = !(is_trim(widx) && cal_busy);

    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (AWVALID && awready_r) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = AWADDR;
        end
        if (WVALID && wready_r) begin
            w_held_nxt = 1'b1;
            wdata_nxt = WDATA;
            wstrb_nxt = WSTRB;
        end
        if (bvalid_r && BREADY) begin
            bvalid_nxt = 1'b0;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `LAOR_RESP_OKAY;
            unique case (widx)
                `LAOR_IDX_ALARM_STATUS, `LAOR_IDX_LANE_FLAGS, `LAOR_IDX_CAL_CTRL,
                `LAOR_IDX_CAL_STAT, `LAOR_IDX_INT_STAT, `LAOR_IDX_INT_MASK: ;
                `LAOR_IDX_TRIM0, `LAOR_IDX_TRIM1: begin
                    if (!wr_ok) bresp_nxt = `LAOR_RESP_SLVERR;
                end
                default: bresp_nxt = `LAOR_RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_held_nxt;
        wready_nxt = !w_held_nxt;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    always_comb begin
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && RREADY) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end else if (!rvalid_r) begin
            arready_nxt = 1'b1;
        end
        if (ARVALID && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = `LAOR_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case (ridx)
                `LAOR_IDX_ALARM_STATUS: rdata_nxt[`LAOR_SUMMARY_BIT] = summary_r;
                `LAOR_IDX_LANE_FLAGS: rdata_nxt[LANES-1:0] = lane_flags_r;
                `LAOR_IDX_TRIM0, `LAOR_IDX_TRIM1: begin
                    if (cal_busy) begin
                        rresp_nxt = `LAOR_RESP_SLVERR;
                    end else begin
                        rdata_nxt[15:0] = (ridx == `LAOR_IDX_TRIM0) ? trim0_r : trim1_r;
                    end
                end
                `LAOR_IDX_CAL_CTRL: rdata_nxt[2:0] = cal_ctrl_r;
                `LAOR_IDX_CAL_STAT: rdata_nxt[1:0] = {cal_busy, cal_foreground_cal_complete};
                `LAOR_IDX_INT_STAT: rdata_nxt[1:0] = int_stat_r;
                `LAOR_IDX_INT_MASK: rdata_nxt[1:0] = int_mask_r;
                default: rresp_nxt = `LAOR_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ****************************************
    // Register update
    // ****************************************
    always_comb begin
        lane_clr = '0;
        if (do_write && widx == `LAOR_IDX_LANE_FLAGS) begin
            lane_clr = wdata_r[LANES-1:0];
        end
        if (do_write && widx == `LAOR_IDX_ALARM_STATUS && wdata_r[`LAOR_SUMMARY_BIT]) begin
            lane_clr = '1;
        end
        // A fault in the clearing cycle wins over the clear
        lane_flags_nxt = (lane_flags_r & ~lane_clr) | fault_s2_r;
        summary_nxt = summary_r;
        if (do_write && widx == `LAOR_IDX_ALARM_STATUS && wdata_r[`LAOR_SUMMARY_BIT]) begin
            summary_nxt = 1'b0;
        end
        if (|fault_s2_r) summary_nxt = 1'b1;

        trim0_nxt = trim0_r;
        trim1_nxt = trim1_r;
        fuse_done_nxt = fuse_done_r;
        // Fuse defaults land once, after reset showed zero
        if (!fuse_done_r && fuse_s2_r) begin
            trim0_nxt = {4'h0, fz0_s2_r};
            trim1_nxt = {4'h0, fz1_s2_r};
            fuse_done_nxt = 1'b1;
        end
        if (do_write && wr_ok && widx == `LAOR_IDX_TRIM0) begin
            trim0_nxt = merge16(trim0_r, wdata_r, wstrb_r);
        end
        if (do_write && wr_ok && widx == `LAOR_IDX_TRIM1) begin
            trim1_nxt = merge16(trim1_r, wdata_r, wstrb_r);
        end

        cal_ctrl_nxt = cal_ctrl_r;
        cal_start_nxt = 1'b0;
        if (do_write && widx == `LAOR_IDX_CAL_CTRL) begin
            cal_ctrl_nxt = wdata_r[2:0];
            cal_start_nxt = wdata_r[`LAOR_CTRL_START];
        end

        int_mask_nxt = int_mask_r;
        if (do_write && widx == `LAOR_IDX_INT_MASK) int_mask_nxt = wdata_r[1:0];
        int_stat_nxt = int_stat_r;
        if (do_write && widx == `LAOR_IDX_INT_STAT) int_stat_nxt = int_stat_r & ~wdata_r[1:0];
        if (|fault_s2_r) int_stat_nxt[`LAOR_INT_LANE] = 1'b1;
        if (cal_done_pulse) int_stat_nxt[`LAOR_INT_CAL] = 1'b1;
        irq_nxt = |(int_stat_nxt & int_mask_nxt);
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lane_flags_r <= `LAOR_LANE_FLAGS_RST;
            summary_r <= `LAOR_SUMMARY_RST;
            trim0_r <= `LAOR_TRIM_RST;
            trim1_r <= `LAOR_TRIM_RST;
            fuse_done_r <= 1'b0;
            cal_ctrl_r <= 3'h0;
            cal_start_r <= 1'b0;
            int_stat_r <= 2'h0;
            int_mask_r <= 2'h0;
            irq_r <= 1'b0;
        end else begin
            lane_flags_r <= lane_flags_nxt;
            summary_r <= summary_nxt;
            trim0_r <= trim0_nxt;
            trim1_r <= trim1_nxt;
            fuse_done_r <= fuse_done_nxt;
            cal_ctrl_r <= cal_ctrl_nxt;
            cal_start_r <= cal_start_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Status mirrors are registered so every output leaves a flip-flop
    logic busy_q_r, spare_q_r;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_q_r <= 1'b0;
            spare_q_r <= 1'b0;
        end else begin
            busy_q_r <= cal_busy;
            spare_q_r <= spare_cal;
        end
    end

    assign AWREADY = awready_r;
    assign WREADY = wready_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = arready_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign CORE0_OFFSET = trim0_r[11:0];
    assign CORE1_OFFSET = trim1_r[11:0];
    assign SPARE_OFS_CAL = spare_q_r;
    assign CAL_BUSY = busy_q_r;
    assign IRQ = irq_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_fault_sets;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (fault_s2_r != '0) |=> ((lane_flags_r & $past(fault_s2_r)) == $past(fault_s2_r));
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("lane fault not flagged");

    property p_w1c;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && widx == `LAOR_IDX_LANE_FLAGS && fault_s2_r == '0)
            |=> (lane_flags_r == ($past(lane_flags_r) & ~$past(wdata_r[LANES-1:0])));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one clear wrong");

    property p_persist;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && widx == `LAOR_IDX_LANE_FLAGS && fault_s2_r[0]) |=> lane_flags_r[0];
    endproperty
    a_persist: assert property (p_persist) else $error("persisting fault lost");

    property p_summary_clr;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && widx == `LAOR_IDX_ALARM_STATUS && wdata_r[`LAOR_SUMMARY_BIT]
            && fault_s2_r == '0) |=> (lane_flags_r == '0) && !summary_r;
    endproperty
    a_summary_clr: assert property (p_summary_clr) else $error("summary clear missed");

    property p_zero_keeps;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && widx == `LAOR_IDX_LANE_FLAGS) |=>
            ((lane_flags_r & ~$past(wdata_r[LANES-1:0])) == (($past(lane_flags_r)
            | $past(fault_s2_r)) & ~$past(wdata_r[LANES-1:0])));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed flag");

    property p_summary_set;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (fault_s2_r != '0) |=> summary_r;
    endproperty
    a_summary_set: assert property (p_summary_set) else $error("summary not set");

    property p_trim_out;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && wr_ok && widx == `LAOR_IDX_TRIM0 && wstrb_r == 4'hf && fuse_done_r)
            |=> CORE0_OFFSET == $past(wdata_r[11:0]) ##1 CORE0_OFFSET == trim0_r[11:0];
    endproperty
    a_trim_out: assert property (p_trim_out) else $error("core0 offset not applied");

    property p_trim_busy;
        @(posedge REF_CLK) disable iff (!ARST_N)
        (do_write && is_trim(widx) && cal_busy)
            |=> $stable(trim0_r) && $stable(trim1_r) && bresp_r == 2'h2;
    endproperty
    a_trim_busy: assert property (p_trim_busy) else $error("trim written while busy");
endmodule // laor_regs
`default_nettype wire

// file: bench/test_laor_regs.sv
// Register-level testbench of the lane alarm and offset trim slice
`include "laor_cfg.svh"
`default_nettype none
module test_laor_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_ALM = {`LAOR_IDX_ALARM_STATUS, 2'b00};
    localparam logic [11:0] A_LANE = {`LAOR_IDX_LANE_FLAGS, 2'b00};
    localparam logic [11:0] A_T0 = {`LAOR_IDX_TRIM0, 2'b00};
    localparam logic [11:0] A_T1 = {`LAOR_IDX_TRIM1, 2'b00};
    localparam logic [11:0] A_CTRL = {`LAOR_IDX_CAL_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {`LAOR_IDX_CAL_STAT, 2'b00};
    localparam logic [11:0] A_INT = {`LAOR_IDX_INT_STAT, 2'b00};
    localparam logic [11:0] A_MSK = {`LAOR_IDX_INT_MASK, 2'b00};
    localparam logic [1:0] OK = `LAOR_RESP_OKAY;
    localparam logic [1:0] ERR = `LAOR_RESP_SLVERR;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] fault = 8'h00;
    logic fuse_v = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [11:0] fuse0 = 12'h5a5, fuse1 = 12'h3c3;
    logic awready, wready, bvalid, arready, rvalid, spare, busy, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    logic [11:0] core0_offset_trim, core1_offset_trim;
    int err_count = 0;
    int n_compared = 0;

    // Short fg step keeps the run brief
    laor_regs #(.ADDR_W(12), .LANES(8), .FG_CYCLES(8)) i_dut (
        .REF_CLK(clk), .ARST_N(arst_n),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .LANE_FIFO_FAULT(fault), .FUSE_VALID(fuse_v),
        .FUSE_TRIM0(fuse0), .FUSE_TRIM1(fuse1), .CORE0_OFFSET(core0_offset_trim),
        .CORE1_OFFSET(core1_offset_trim), .SPARE_OFS_CAL(spare), .CAL_BUSY(busy), .IRQ(irq)
    );

    always #12.5 clk = ~clk;

    // ********************
    // Bus tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Level outputs looked at mid-cycle, clear of the edge
    task automatic ck1(input string nm, input logic e, input logic g_unused);
        @(negedge clk);
        chk(nm, {31'h0, e}, {31'h0, (nm == "irq") ? irq : busy});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ev, input logic [1:0] er,
                      input string nm);
        logic ar, v;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ar = arvalid & arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
        chk(nm, ev, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic cal(input logic [31:0] c, input logic sp);
        logic seen;
        seen = 1'b0;
        wr(A_CTRL, c, OK);
        // Busy mirror lags the start by a cycle
        @(posedge clk);
        ck1("busy", 1'b1, 1'b0);
        rd(A_T0, 32'h0, ERR, "trim0_busy");
        repeat (20) begin
            @(negedge clk);
            seen = seen | spare;
        end
        chk("spare", {31'h0, sp}, {31'h0, seen});
        rd(A_STAT, 32'h1, OK, "cal_stat");
        rd(A_T0, 32'habc, OK, "trim0");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ********************
    // Tests
    // ********************
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(A_LANE, 32'hff, OK, "lane_flags");
        rd(A_ALM, 32'h20, OK, "summary");
        rd(A_T0, 32'h0, OK, "trim0");
        chk("core0", 32'h0, {20'h0, core0_offset_trim});
        fuse_v <= 1'b1;
        repeat (5) @(posedge clk);
        rd(A_T0, 32'h5a5, OK, "trim0_fuse");
        chk("core1", 32'h3c3, {20'h0, core1_offset_trim});
        rd(12'hffc, 32'h0, ERR, "unmapped");
        $display("test reset done");
        wr(A_LANE, 32'h0f, OK);
        rd(A_LANE, 32'hf0, OK, "lane_flags");
        wr(A_LANE, 32'h00, OK);
        rd(A_LANE, 32'hf0, OK, "lane_flags");
        wr(A_ALM, 32'h20, OK);
        rd(A_LANE, 32'h00, OK, "lane_flags");
        rd(A_ALM, 32'h00, OK, "summary");
        $display("test clear done");
        for (int i = 0; i < 8; i++) begin
            fault <= 8'h01 << i;
            repeat (4) @(posedge clk);
            rd(A_LANE, 32'h1 << i, OK, "lane_flags");
            rd(A_ALM, 32'h20, OK, "summary");
            wr(A_LANE, 32'h1 << i, OK);
            rd(A_LANE, 32'h1 << i, OK, "lane_flags");
            fault <= 8'h00;
            repeat (4) @(posedge clk);
            wr(A_ALM, 32'h20, OK);
            rd(A_LANE, 32'h0, OK, "lane_flags");
        end
        $display("test lanes done");
        wr(A_T0, 32'h0abc, OK);
        wr(A_T1, 32'h0123, OK);
        rd(A_T0, 32'habc, OK, "trim0");
        rd(A_T1, 32'h123, OK, "trim1");
        chk("core0", 32'habc, {20'h0, core0_offset_trim});
        chk("core1", 32'h123, {20'h0, core1_offset_trim});
        wstrb <= 4'h2;
        wr(A_T1, 32'h0900, OK);
        rd(A_T1, 32'h923, OK, "trim1_strobe");
        wstrb <= 4'hf;
        $display("test trims done");
        cal(32'h9, 1'b0);
        cal(32'hb, 1'b1);
        wr(A_CTRL, 32'hf, OK);
        repeat (20) @(posedge clk);
        ck1("busy", 1'b1, 1'b0);
        wr(A_T1, 32'h0456, ERR);
        rd(A_STAT, 32'h3, OK, "cal_stat");
        wr(A_CTRL, 32'h0, OK);
        repeat (3) @(posedge clk);
        wr(A_T1, 32'h0456, OK);
        rd(A_T1, 32'h456, OK, "trim1");
        chk("core1", 32'h456, {20'h0, core1_offset_trim});
        $display("test calibration done");
        wr(A_INT, 32'h3, OK);
        wr(A_MSK, 32'h1, OK);
        ck1("irq", 1'b0, 1'b0);
        fault <= 8'h04;
        repeat (6) @(posedge clk);
        ck1("irq", 1'b1, 1'b0);
        wr(A_MSK, 32'h0, OK);
        ck1("irq", 1'b0, 1'b0);
        rd(A_INT, 32'h1, OK, "int_stat");
        fault <= 8'h00;
        repeat (4) @(posedge clk);
        wr(A_ALM, 32'h20, OK);
        wr(A_INT, 32'h1, OK);
        wr(A_MSK, 32'h1, OK);
        ck1("irq", 1'b0, 1'b0);
        $display("test interrupt done");
        stop_test();
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end
endmodule // test_laor_regs
`default_nettype wire
